// File: hw/lf_ctl_pkg.sv
// Package: register map, field layout and timing constants for the main control register
package lf_ctl_pkg;
  localparam logic [7:0] main_ctl_addr      = 8'h20;
  localparam logic [7:0] main_ctl_reset     = 8'h00;
  localparam int         bit_receiver_on    = 7;
  localparam int         bit_soft_reset     = 6;
  localparam int         bit_carrier_mode   = 5;
  localparam int         bit_page_select    = 4;
  localparam int         autozero_time_ns   = 64000;
  localparam int         clk_period_ns      = 5;
  // Least time, rounded up to whole clock cycles
  localparam int         autozero_cycles    = (autozero_time_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [1:0] id_none            = 2'h0;
  localparam logic [1:0] id_low8            = 2'h1;
  localparam logic [1:0] id_full16          = 2'h2;
  localparam logic [1:0] id_either8         = 2'h3;

  typedef struct packed {
    logic       receiver_on;
    logic       soft_reset_trigger;
    logic       carrier_mode_select;
    logic       register_page_select;
    logic [1:0] wakeup_id_select;
    logic [1:0] sensitivity_select;
  } main_ctl_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] first;
    logic [7:0] second;
    logic       two_bytes;
  } rx_id_t;

  typedef enum logic [1:0] {
    st_standby  = 2'b00,
    st_wait_osc = 2'b01,
    st_power_up = 2'b10,
    st_autozero = 2'b11
  } rx_state_t;
endpackage : lf_ctl_pkg

// File: hw/lf_receiver_main_control.sv
// Main control register of the low-frequency wake-up receiver with power-up sequencer
module lf_receiver_main_control
  import lf_ctl_pkg::*;
#(
  parameter int autozero_len = autozero_cycles
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  low_freq_osc_clock,
  input  wire logic [7:0]            wakeup_id_low,
  input  wire logic [7:0]            wakeup_id_high,
  input  wire lf_ctl_pkg::rx_id_t    rx_id,
  input  wire logic                  carrier_seen,
  input  wire logic                  carrier_detect_irq_enable,
  output logic                       receiver_active,
  output logic                       receiver_ready,
  output logic                       soft_reset_pulse,
  output logic                       carrier_mode,
  output logic                       page_select,
  output logic [1:0]                 det_threshold,
  output logic                       id_match,
  output logic                       carrier_wake
);
  import lf_ctl_pkg::*;

  // ----------------------------------------------------------------
  // Register
  // ----------------------------------------------------------------
  main_ctl_t ctl_q, ctl_d;
  logic      srst_q;
  wire       hit   = reg_addr == main_ctl_addr;
  wire       wr_en = reg_wr && hit;
  main_ctl_t wr_val;
  assign wr_val = main_ctl_t'(reg_wdata);

  // soft reset clears ID select too
  always_comb begin
    ctl_d = ctl_q;
    if (srst_q) begin
      ctl_d.register_page_select = 1'b0;
      ctl_d.wakeup_id_select     = id_none;
    end
    // A write in the same cycle wins over the clear
    if (wr_en) begin
      ctl_d = wr_val;
    end
    ctl_d.soft_reset_trigger = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_q  <= main_ctl_t'(main_ctl_reset);
      srst_q <= 1'b0;
    end else begin
      ctl_q  <= ctl_d;
      srst_q <= wr_en && wr_val.soft_reset_trigger;
    end
  end

  wire [7:0] rd_val = hit ? 8'(ctl_q) : 8'h00;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_val;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator edge detect
  // ----------------------------------------------------------------
  // Oscillator runs free of sys_clk
  // Two-stage sync; first stage feeds only the second
  logic osc_s1_q, osc_s2_q, osc_s3_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= low_freq_osc_clock;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end
  wire osc_rise = osc_s2_q && !osc_s3_q;

  // ----------------------------------------------------------------
  // Power-up sequencer
  // ----------------------------------------------------------------
  rx_state_t st_q, st_d;
  logic [$clog2(autozero_len+1)-1:0] az_q, az_d;
  localparam int az_w = $clog2(autozero_len+1);

  // osc edge, one osc cycle, then auto-zero
  always_comb begin
    st_d = st_q;
    az_d = az_q;
    unique case (st_q)
      st_standby:  if (ctl_q.receiver_on) st_d = st_wait_osc;
      st_wait_osc: if (osc_rise) st_d = st_power_up;
      st_power_up: if (osc_rise) begin
        st_d = st_autozero;
        az_d = az_w'(autozero_len - 1);
      end
      st_autozero: if (az_q != '0) az_d = az_q - az_w'(1);
    endcase
    // Abort at once; software must idle two osc cycles
    if (!ctl_q.receiver_on || srst_q) begin
      st_d = st_standby;
      az_d = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= st_standby;
      az_q <= '0;
    end else begin
      st_q <= st_d;
      az_q <= az_d;
    end
  end

  // ----------------------------------------------------------------
  // ID compare and outputs
  // ----------------------------------------------------------------
  // ID length and source selection
  // either byte matches in mode 11
  function automatic logic id_ok(input logic [1:0] sel, input rx_id_t id,
                                 input logic [7:0] lo, input logic [7:0] hi);
    unique case (sel)
      id_none:   id_ok = 1'b1;
      id_low8:   id_ok = !id.two_bytes && id.first == lo;
      id_full16: id_ok = id.two_bytes && id.first == hi && id.second == lo;
      id_either8: id_ok = !id.two_bytes && (id.first == lo || id.first == hi);
    endcase
  endfunction
  wire match_d = rx_id.valid && id_ok(ctl_q.wakeup_id_select, rx_id,
                                      wakeup_id_low, wakeup_id_high);
  wire ready_d = st_q == st_autozero && az_q == '0;
  // carrier mode wakes host if enabled
  wire wake_d  = ready_d && ctl_q.carrier_mode_select && carrier_seen
                 && carrier_detect_irq_enable;

  // Carrier mode ignores IDs, it only looks for a carrier
  wire id_hit_d = match_d && ready_d && !ctl_q.carrier_mode_select;

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  // Registered so the host never sees a decode glitch
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      receiver_active <= 1'b0;
      receiver_ready  <= 1'b0;
    end else begin
      receiver_active <= st_q != st_standby;
      receiver_ready  <= ready_d;
    end
  end

  // ----------------------------------------------------------------
  // Field copies
  // ----------------------------------------------------------------
  // threshold code passed through
  // page bit forwarded to paged decode
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      carrier_mode  <= 1'b0;
      page_select   <= 1'b0;
      det_threshold <= 2'h0;
    end else begin
      carrier_mode  <= ctl_q.carrier_mode_select;
      page_select   <= ctl_q.register_page_select;
      det_threshold <= ctl_q.sensitivity_select;
    end
  end

  // ----------------------------------------------------------------
  // Event outputs
  // ----------------------------------------------------------------
  // Soft reset and ID pulses last as long as the soft reset write or the ID valid does
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      soft_reset_pulse <= 1'b0;
      id_match         <= 1'b0;
      carrier_wake     <= 1'b0;
    end else begin
      soft_reset_pulse <= srst_q;
      id_match         <= id_hit_d;
      carrier_wake     <= wake_d;
    end
  end
endmodule // lf_receiver_main_control

// File: test/lf_ctl_checker.sv
// Assertions on the main control register ports
module lf_ctl_checker
  import lf_ctl_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               rstn,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic [7:0]         reg_rdata,
  input wire lf_ctl_pkg::rx_id_t rx_id,
  input wire logic               receiver_active,
  input wire logic               receiver_ready,
  input wire logic               soft_reset_pulse,
  input wire logic               carrier_mode,
  input wire logic               page_select,
  input wire logic [1:0]         det_threshold,
  input wire logic               id_match
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Soft reset writes excluded, they clear fields
  sequence ctl_wr;
    reg_wr && reg_addr == main_ctl_addr && !reg_wdata[6];
  endsequence
  srst_pulse_a: assert property (
    reg_wr && reg_addr == main_ctl_addr && reg_wdata[6] |-> ##2 soft_reset_pulse) else $error("no pulse");
  page_copy_a: assert property (
    ctl_wr |-> ##2 page_select == $past(reg_wdata[4], 2)) else $error("page wrong");
  mode_copy_a: assert property (
    ctl_wr |-> ##2 carrier_mode == $past(reg_wdata[5], 2)) else $error("mode wrong");
  thr_copy_a: assert property (
    ctl_wr |-> ##2 det_threshold == $past(reg_wdata[1:0], 2)) else $error("threshold wrong");
  unmapped_rd_a: assert property (
    reg_rd && reg_addr != main_ctl_addr |=> reg_rdata == 8'h00) else $error("unmapped read");
  ready_on_a: assert property (
    receiver_ready |-> receiver_active) else $error("ready in standby");
  ready_wait_a: assert property (
    $rose(receiver_active) |-> !receiver_ready [*8]) else $error("ready too early");
  id_cause_a: assert property (
    id_match |-> $past(rx_id.valid)) else $error("match without id");
  standby_off_a: assert property (
    reg_wr && reg_addr == main_ctl_addr && !reg_wdata[7] |-> ##3 !receiver_active)
    else $error("active after disable");
  srst_read_a: assert property (
    reg_rd |=> !reg_rdata[6]) else $error("soft reset bit read as one");
endmodule // lf_ctl_checker

bind lf_receiver_main_control lf_ctl_checker i_chk (.sys_clk(sys_clk), .rstn(rstn),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .rx_id(rx_id), .receiver_active(receiver_active),
  .receiver_ready(receiver_ready), .soft_reset_pulse(soft_reset_pulse),
  .carrier_mode(carrier_mode), .page_select(page_select),
  .det_threshold(det_threshold), .id_match(id_match));

// File: test/tb.sv
// Self-checking bench for the main control register
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lf_ctl_pkg::*;
  logic sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, osc = 0, seen = 0, irq_en = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, rd_v, rdata;
  logic act, rdy, srst, cmode, page, wake, idm;
  logic [1:0] thr;
  rx_id_t rx_id = '0;
  int num_errors = 0, checks_done = 0, n = 0;
  // Written value beside expected readback
  logic [15:0] rows [6] = '{16'h2020, 16'h1e1e, 16'h0606, 16'h2929, 16'h1b1b, 16'h7a22};
  lf_receiver_main_control #(.autozero_len(8)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(rdata), .low_freq_osc_clock(osc), .wakeup_id_low(8'h5a),
    .wakeup_id_high(8'h3c), .rx_id(rx_id), .carrier_seen(seen),
    .carrier_detect_irq_enable(irq_en), .receiver_active(act), .receiver_ready(rdy),
    .soft_reset_pulse(srst), .carrier_mode(cmode), .page_select(page),
    .det_threshold(thr), .id_match(idm), .carrier_wake(wake));
  always #2.5 sys_clk = ~sys_clk;
  // Slow oscillator, 20 clocks a period
  always @(posedge sys_clk) begin
    n <= n + 1;
    if (n % 10 == 9) osc <= ~osc;
  end
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 rd_v = rdata;
  endtask
  // Restart after two idle oscillator periods
  task automatic start(input logic [7:0] d);
    int i;
    wr(main_ctl_addr, 8'h00);
    repeat (45) @(posedge sys_clk);
    chk("standby", 8'(act), 8'h00);
    wr(main_ctl_addr, d);
    for (i = 0; i < 300 && rdy !== 1'b1; i++) @(posedge sys_clk);
    if (rdy !== 1'b1) begin
      num_errors++;
      end_sim;
    end else begin
      chk("active", 8'(act), 8'h01);
      chk("ready time", 8'(i >= 28 && i <= 60), 8'h01);
    end
  endtask
  task automatic send_id(input logic [7:0] f, input logic [7:0] s, input logic two,
                         input logic e);
    @(posedge sys_clk);
    rx_id <= '{1'b1, f, s, two};
    @(posedge sys_clk);
    rx_id <= '0;
    #1 chk("id", 8'(idm), 8'(e));
  endtask
  initial begin
    #50us;
    num_errors++;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1;
    rd(main_ctl_addr);
    chk("reset", rd_v, main_ctl_reset);
    foreach (rows[k]) begin
      wr(main_ctl_addr, rows[k][15:8]);
      rd(main_ctl_addr);
      chk("readback", rd_v, rows[k][7:0]);
      chk("page", 8'(page), 8'(rows[k][4]));
      chk("thr", 8'(thr), 8'(rows[k][1:0]));
      chk("mode", 8'(cmode), 8'(rows[k][5]));
    end
    wr(main_ctl_addr, 8'h40);
    rd(main_ctl_addr);
    chk("srst", rd_v, 8'h00);
    rd(8'h21);
    chk("unmapped", rd_v, 8'h00);
    start(8'h8c);
    send_id(8'h3c, 8'h00, 1'b0, 1'b1);
    send_id(8'h5a, 8'h00, 1'b0, 1'b1);
    send_id(8'h77, 8'h00, 1'b0, 1'b0);
    start(8'h84);
    send_id(8'h5a, 8'h00, 1'b0, 1'b1);
    send_id(8'h3c, 8'h00, 1'b0, 1'b0);
    start(8'h88);
    send_id(8'h3c, 8'h5a, 1'b1, 1'b1);
    send_id(8'h5a, 8'h3c, 1'b1, 1'b0);
    start(8'h80);
    send_id(8'h77, 8'h00, 1'b0, 1'b1);
    start(8'ha1);
    seen <= 1;
    irq_en <= 1;
    repeat (2) @(posedge sys_clk);
    #1 chk("wake", 8'(wake), 8'h01);
    @(posedge sys_clk);
    irq_en <= 0;
    repeat (2) @(posedge sys_clk);
    #1 chk("no wake", 8'(wake), 8'h00);
    wr(main_ctl_addr, 8'h0c);
    @(posedge sys_clk);
    rstn <= 0;
    repeat (2) @(posedge sys_clk);
    #1 chk("in reset", {act, rdy, srst, cmode, page, wake, idm, |thr}, 8'h00);
    @(posedge sys_clk);
    rstn <= 1;
    rd(main_ctl_addr);
    chk("idsel reset", rd_v, 8'h00);
    end_sim;
  end
endmodule // tb
